// ===== iosd_pkg.sv
// Package for the I/O space decoder: map, opcodes and the core request struct
package iosd_pkg;
   // ----------------------------------------
   // Address map
   // ----------------------------------------
   localparam logic [7:0] IO_PORT_MAX   = 8'h3F;
   localparam logic [7:0] IO_DATA_OFS   = 8'h20;
   localparam logic [7:0] IO_BIT_MAX    = 8'h1F;
   localparam logic [7:0] IO_EXT_LO     = 8'h60;
   localparam logic [7:0] IO_EXT_HI     = 8'hFF;
   localparam logic [7:0] ADDR_SCRATCH0 = 8'h1E;
   localparam logic [7:0] ADDR_SCRATCH1 = 8'h19;
   localparam logic [7:0] ADDR_SCRATCH2 = 8'h1A;
   localparam logic [7:0] ADDR_SCRATCH3 = 8'h1B;
   localparam logic [7:0] SCRATCH_RST   = 8'h00;
   localparam int         NUM_SCRATCH   = 4;

   // ----------------------------------------
   // Core operations
   // ----------------------------------------
   typedef enum logic [2:0] {
      IOSD_OP_NONE,
      IOSD_OP_PORT_RD,
      IOSD_OP_PORT_WR,
      IOSD_OP_DATA_LD,
      IOSD_OP_DATA_WR,
      IOSD_OP_BIT_SET,
      IOSD_OP_BIT_CLR,
      IOSD_OP_BIT_TST
   } iosd_op_e;

   typedef struct packed {
      iosd_op_e   op;
      logic [7:0] addr;
      logic [2:0] bit_sel;
      logic [7:0] wdata;
   } iosd_req_s;
endpackage : iosd_pkg

// ===== iosd_byte_reg.sv
// One scratch byte with write strobe and per-bit enable
`timescale 1ns/1ps
`default_nettype none
module iosd_byte_reg
   import iosd_pkg::*;
#(
   parameter int W = 8
) (
   input  wire logic         i_clk,
   input  wire logic         i_rst,
   input  wire logic [W-1:0] i_wen,
   input  wire logic [W-1:0] i_wdata,
   output logic [W-1:0]      o_q
);
   logic [W-1:0] q_q;
   logic [W-1:0] q_d;

   assign q_d = (q_q & ~i_wen) | (i_wdata & i_wen);
   assign o_q = q_q;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         q_q <= W'(SCRATCH_RST);
      end else begin
         q_q <= q_d;
      end
   end
endmodule : iosd_byte_reg
`default_nettype wire

// ===== iosd_decoder.sv
// I/O space decoder with bit access and scratch registers
//
// Functional notes
// - Port read/write reaches only I/O addresses 0x00 to 0x3F.
// - Data-space access at I/O address plus 0x20 hits that register.
// - Extended range 0x60-0xDF only via data load and memory write; 0xE0-0xFF unreachable.
// - Bit set/clear works at 0x00-0x1F only, ignored above.
// - Bit test returns selected bit of a low register for skipping.
// - Write-one-to-clear flags clear on one, unchanged on zero.
// - Bit set/clear strobes only the addressed bit.
`timescale 1ns/1ps
`default_nettype none
module iosd_decoder
   import iosd_pkg::*;
(
   input  wire logic      I_CLK,
   input  wire logic      I_RST,
   input  wire iosd_req_s I_REQ,
   input  wire logic [7:0] I_PERIPH_RDATA,
   input  wire logic      I_PERIPH_HIT,
   output logic [7:0]     O_RDATA,
   output logic           O_RVALID,
   output logic           O_BIT_VAL,
   output logic           O_BIT_VALID,
   output logic [7:0]     O_PERIPH_ADDR,
   output logic [7:0]     O_PERIPH_WEN,
   output logic [7:0]     O_PERIPH_WDATA,
   output logic           O_PERIPH_RD
);
   // ----------------------------------------
   // Address translation to I/O space
   // ----------------------------------------
   logic       is_port;
   logic       is_data;
   logic       is_bit;
   logic       is_wr;
   logic       is_rd;
   logic       addr_ok;
   logic [7:0] io_addr;

   assign is_port = (I_REQ.op == IOSD_OP_PORT_RD) || (I_REQ.op == IOSD_OP_PORT_WR);
   assign is_data = (I_REQ.op == IOSD_OP_DATA_LD) || (I_REQ.op == IOSD_OP_DATA_WR);
   assign is_bit  = (I_REQ.op == IOSD_OP_BIT_SET) || (I_REQ.op == IOSD_OP_BIT_CLR)
                  || (I_REQ.op == IOSD_OP_BIT_TST);
   // Data space: below the offset is the register file, not ours
   assign io_addr = is_data ? 8'(I_REQ.addr - IO_DATA_OFS) : I_REQ.addr;
   assign addr_ok = is_port ? (I_REQ.addr <= IO_PORT_MAX)
                  : is_bit ? (I_REQ.addr <= IO_BIT_MAX)
                  : is_data ? (I_REQ.addr >= IO_DATA_OFS)
                  : 1'b0;
   assign is_wr = addr_ok && ((I_REQ.op == IOSD_OP_PORT_WR) || (I_REQ.op == IOSD_OP_DATA_WR));
   assign is_rd = addr_ok && ((I_REQ.op == IOSD_OP_PORT_RD) || (I_REQ.op == IOSD_OP_DATA_LD));

   // ----------------------------------------
   // Write strobes and data
   // ----------------------------------------
   logic [7:0] bit_mask;
   logic       bit_wr;
   logic [7:0] wen;
   logic [7:0] wdata;

   assign bit_mask = 8'h01 << I_REQ.bit_sel;
   assign bit_wr   = addr_ok && ((I_REQ.op == IOSD_OP_BIT_SET) || (I_REQ.op == IOSD_OP_BIT_CLR));
   // Single-bit strobe keeps other W1C flags intact
   assign wen   = is_wr ? 8'hFF : (bit_wr ? bit_mask : 8'h00);
   assign wdata = is_wr ? I_REQ.wdata
                : ((I_REQ.op == IOSD_OP_BIT_SET) ? bit_mask : 8'h00);

   // ----------------------------------------
   // Scratch registers
   // ----------------------------------------
   localparam logic [7:0] SCR_ADDR [NUM_SCRATCH] =
      '{ADDR_SCRATCH0, ADDR_SCRATCH1, ADDR_SCRATCH2, ADDR_SCRATCH3};
   logic [7:0] scr_q   [NUM_SCRATCH];
   logic [NUM_SCRATCH-1:0] scr_hit;

   genvar g;
   generate
      for (g = 0; g < NUM_SCRATCH; g++) begin : g_scr
         assign scr_hit[g] = addr_ok && (io_addr == SCR_ADDR[g]);
         iosd_byte_reg #(.W(8)) u_reg (
            .i_clk   (I_CLK),
            .i_rst   (I_RST),
            .i_wen   (scr_hit[g] ? wen : 8'h00),
            .i_wdata (wdata),
            .o_q     (scr_q[g])
         );
      end
   endgenerate

   // ----------------------------------------
   // Read selection
   // ----------------------------------------
   logic [7:0] rd_sel;
   logic       any_scr;

   assign any_scr = |scr_hit;
   always_comb begin
      rd_sel = 8'h00;
      for (int i = 0; i < NUM_SCRATCH; i++) begin
         if (scr_hit[i]) begin
            rd_sel = scr_q[i];
         end
      end
      if (!any_scr && I_PERIPH_HIT) begin
         rd_sel = I_PERIPH_RDATA;
      end
   end

   logic       bit_tst;
   assign bit_tst = addr_ok && (I_REQ.op == IOSD_OP_BIT_TST);

   // ----------------------------------------
   // Registered outputs
   // ----------------------------------------
   logic [7:0] rdata_q;
   logic       rvalid_q;
   logic       bitv_q;
   logic       bitvalid_q;
   logic [7:0] paddr_q;
   logic [7:0] pwen_q;
   logic [7:0] pwdata_q;
   logic       prd_q;

   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         rdata_q    <= 8'h00;
         rvalid_q   <= 1'b0;
         bitv_q     <= 1'b0;
         bitvalid_q <= 1'b0;
         paddr_q    <= 8'h00;
         pwen_q     <= 8'h00;
         pwdata_q   <= 8'h00;
         prd_q      <= 1'b0;
      end else begin
         rdata_q    <= is_rd ? rd_sel : 8'h00;
         rvalid_q   <= is_rd;
         bitv_q     <= bit_tst & rd_sel[I_REQ.bit_sel];
         bitvalid_q <= bit_tst;
         paddr_q    <= addr_ok ? io_addr : 8'h00;
         pwen_q     <= any_scr ? 8'h00 : wen;
         pwdata_q   <= wdata;
         prd_q      <= (is_rd || bit_tst) && !any_scr && I_PERIPH_HIT;
      end
   end

   assign O_RDATA        = rdata_q;
   assign O_RVALID       = rvalid_q;
   assign O_BIT_VAL      = bitv_q;
   assign O_BIT_VALID    = bitvalid_q;
   assign O_PERIPH_ADDR  = paddr_q;
   assign O_PERIPH_WEN   = pwen_q;
   assign O_PERIPH_WDATA = pwdata_q;
   assign O_PERIPH_RD    = prd_q;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   a_bit_high_ignored: assert property (@(posedge I_CLK) disable iff (I_RST)
      ((I_REQ.op == IOSD_OP_BIT_SET || I_REQ.op == IOSD_OP_BIT_CLR) && I_REQ.addr > IO_BIT_MAX)
      |=> (O_PERIPH_WEN == 8'h00))
      else $error("bit op above low range produced a strobe");
   a_bit_one_strobe: assert property (@(posedge I_CLK) disable iff (I_RST)
      (bit_wr && !any_scr) |=> (O_PERIPH_WEN == (8'h01 << $past(I_REQ.bit_sel))))
      else $error("bit op strobed other than the addressed bit");
   a_port_range: assert property (@(posedge I_CLK) disable iff (I_RST)
      (is_port && I_REQ.addr > IO_PORT_MAX) |=> (!O_RVALID && O_PERIPH_WEN == 8'h00))
      else $error("port access beyond range took effect");
   a_scratch_hold: assert property (@(posedge I_CLK) disable iff (I_RST)
      (I_REQ.op == IOSD_OP_PORT_WR && I_REQ.addr == ADDR_SCRATCH2)
      ##1 (I_REQ.op == IOSD_OP_PORT_RD && I_REQ.addr == ADDR_SCRATCH2)
      |=> (O_RDATA == $past(I_REQ.wdata, 2)))
      else $error("scratch byte did not return written value");
   a_data_offset: assert property (@(posedge I_CLK) disable iff (I_RST)
      (I_REQ.op == IOSD_OP_DATA_LD && I_REQ.addr >= IO_DATA_OFS)
      |=> (O_PERIPH_ADDR == 8'($past(I_REQ.addr) - IO_DATA_OFS)))
      else $error("data address not shifted by offset");
   a_reserved_zero: assert property (@(posedge I_CLK) disable iff (I_RST)
      (is_rd && !any_scr && !I_PERIPH_HIT) |=> (O_RDATA == 8'h00 && !O_PERIPH_RD))
      else $error("unclaimed read returned nonzero");
   a_bit_test: assert property (@(posedge I_CLK) disable iff (I_RST)
      (I_REQ.op == IOSD_OP_BIT_TST && I_REQ.addr > IO_BIT_MAX) |=> !O_BIT_VALID)
      else $error("bit test answered above low range");
   a_clr_zero_data: assert property (@(posedge I_CLK) disable iff (I_RST)
      (bit_wr && I_REQ.op == IOSD_OP_BIT_CLR && !any_scr)
      |=> (O_PERIPH_WDATA == 8'h00 && $onehot(O_PERIPH_WEN)))
      else $error("bit clear wrote a one");
endmodule : iosd_decoder
`default_nettype wire

// ===== iosd_periph_model.sv
// Peripheral model: plain byte, extended byte and write-one-to-clear flag byte
`timescale 1ns/1ps
`default_nettype none
module iosd_periph_model
   import iosd_pkg::*;
(
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   input  wire iosd_req_s  i_req,
   input  wire logic [7:0] i_addr,
   input  wire logic [7:0] i_wen,
   input  wire logic [7:0] i_wdata,
   output logic [7:0]      o_rdata,
   output logic            o_hit
);
   logic [7:0] plain_q;
   logic [7:0] ext_q;
   logic [7:0] flag_q;
   logic [7:0] io_a;
   logic [7:0] sel;
   logic       data_op;
   assign data_op = (i_req.op == IOSD_OP_DATA_LD) || (i_req.op == IOSD_OP_DATA_WR);
   assign io_a    = data_op ? i_req.addr - IO_DATA_OFS : i_req.addr;
   assign o_hit   = (io_a == 8'h05) || (io_a == 8'h16) || (io_a == 8'h60);
   assign sel     = (io_a == 8'h16) ? flag_q : ((io_a == 8'h60) ? ext_q : plain_q);
   // Unclaimed reads show junk, so the decoder must gate them
   assign o_rdata = o_hit ? sel : ~sel;
   always @(posedge i_clk) begin
      if (i_rst) begin
         plain_q <= 8'h00;
         ext_q   <= 8'h00;
         flag_q  <= 8'h0F;
      end else begin
         if (i_addr == 8'h05) plain_q <= (plain_q & ~i_wen) | (i_wdata & i_wen);
         if (i_addr == 8'h60) ext_q <= (ext_q & ~i_wen) | (i_wdata & i_wen);
         if (i_addr == 8'h16) flag_q <= flag_q & ~(i_wen & i_wdata);
      end
   end
endmodule : iosd_periph_model
`default_nettype wire

// ===== io_space_decoder_bench.sv
// Sequence bench for the I/O space decoder
`timescale 1ns/1ps
`default_nettype none
module io_space_decoder_bench;
   import iosd_pkg::*;
   logic       clk = 1'b0;
   logic       rst = 1'b1;
   iosd_req_s  req = '0;
   logic [7:0] p_rdata, rdata, p_addr, p_wen, p_wdata;
   logic       p_hit, rvalid, bval, bvalid, p_rd;
   int         fails = 0;
   int         n_compared = 0;
   int         cyc = 0;
   logic [7:0] scr [4] = '{ADDR_SCRATCH0, ADDR_SCRATCH1, ADDR_SCRATCH2, ADDR_SCRATCH3};
   always #2.5 clk = ~clk;
   iosd_decoder i_dut (.I_CLK(clk), .I_RST(rst), .I_REQ(req), .I_PERIPH_RDATA(p_rdata),
      .I_PERIPH_HIT(p_hit), .O_RDATA(rdata), .O_RVALID(rvalid), .O_BIT_VAL(bval),
      .O_BIT_VALID(bvalid), .O_PERIPH_ADDR(p_addr), .O_PERIPH_WEN(p_wen),
      .O_PERIPH_WDATA(p_wdata), .O_PERIPH_RD(p_rd));
   iosd_periph_model i_periph (.i_clk(clk), .i_rst(rst), .i_req(req), .i_addr(p_addr),
      .i_wen(p_wen), .i_wdata(p_wdata), .o_rdata(p_rdata), .o_hit(p_hit));
   task end_sim;
      if (fails == 0 && n_compared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : end_sim
   task chk(input logic ok, input string what);
      n_compared++;
      if (ok !== 1'b1) begin
         fails++;
         $display("Error at %0t: %s", $time, what);
      end
   endtask : chk
   // Called at a falling edge; returns one falling edge after the taking edge
   task do_op(input iosd_op_e op, input logic [7:0] a, input logic [2:0] b,
              input logic [7:0] wd);
      req = '{op, a, b, wd};
      @(negedge clk);
   endtask : do_op
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         fails++;
         $display("Error at %0t: timeout", $time);
         end_sim();
      end
   end
   initial begin
      repeat (10) @(negedge clk);
      rst = 1'b0;
      foreach (scr[i]) begin
         do_op(IOSD_OP_PORT_WR, scr[i], 3'd0, 8'(8'hA0 + i));
         chk(p_wen === 8'h00, "scratch strobe leak");
         do_op(IOSD_OP_DATA_LD, scr[i] + IO_DATA_OFS, 3'd0, 8'h00);
         chk(rvalid === 1'b1 && rdata === 8'(8'hA0 + i), "scratch readback");
      end
      // Port write then port read back to back on one scratch byte
      do_op(IOSD_OP_PORT_WR, ADDR_SCRATCH2, 3'd0, 8'h5A);
      do_op(IOSD_OP_PORT_RD, ADDR_SCRATCH2, 3'd0, 8'h00);
      chk(rvalid === 1'b1 && rdata === 8'h5A && p_rd === 1'b0, "scratch port read");
      do_op(IOSD_OP_BIT_TST, ADDR_SCRATCH0, 3'd5, 8'h00);
      chk(bvalid === 1'b1 && bval === 1'b1, "scratch bit test");
      do_op(IOSD_OP_BIT_SET, 8'h05, 3'd3, 8'h00);
      chk(p_addr === 8'h05 && p_wen === 8'h08 && p_wdata === 8'h08, "bit set");
      do_op(IOSD_OP_BIT_CLR, 8'h05, 3'd3, 8'hFF);
      chk(p_wen === 8'h08 && p_wdata === 8'h00, "bit clear");
      do_op(IOSD_OP_BIT_SET, 8'h20, 3'd3, 8'h00);
      chk(p_wen === 8'h00, "bit set above range");
      do_op(IOSD_OP_BIT_TST, 8'h20, 3'd0, 8'h00);
      chk(bvalid === 1'b0, "bit test above range");
      do_op(IOSD_OP_PORT_RD, 8'h40, 3'd0, 8'h00);
      chk(rvalid === 1'b0, "port read past range");
      do_op(IOSD_OP_PORT_RD, 8'h3F, 3'd0, 8'h00);
      chk(rvalid === 1'b1 && p_addr === 8'h3F, "port read top");
      do_op(IOSD_OP_PORT_WR, 8'h60, 3'd0, 8'h55);
      chk(p_wen === 8'h00, "port write to extended");
      do_op(IOSD_OP_DATA_WR, 8'h80, 3'd0, 8'h3C);
      chk(p_addr === 8'h60 && p_wen === 8'hFF && p_wdata === 8'h3C, "ext write");
      do_op(IOSD_OP_NONE, 8'h00, 3'd0, 8'h00);
      do_op(IOSD_OP_DATA_LD, 8'h80, 3'd0, 8'h00);
      chk(rvalid === 1'b1 && rdata === 8'h3C, "ext read");
      // Flags start at 0x0F; clear-op writes zero and must not clear
      do_op(IOSD_OP_BIT_CLR, 8'h16, 3'd0, 8'h00);
      do_op(IOSD_OP_PORT_WR, 8'h16, 3'd0, 8'h02);
      do_op(IOSD_OP_NONE, 8'h00, 3'd0, 8'h00);
      do_op(IOSD_OP_PORT_RD, 8'h16, 3'd0, 8'h00);
      chk(rvalid === 1'b1 && rdata === 8'h0D, "flag byte");
      chk(p_rd === 1'b1, "flag read strobe");
      do_op(IOSD_OP_BIT_TST, 8'h16, 3'd1, 8'h00);
      chk(bvalid === 1'b1 && bval === 1'b0, "flag bit test");
      do_op(IOSD_OP_PORT_RD, 8'h02, 3'd0, 8'h00);
      chk(rvalid === 1'b1 && rdata === 8'h00 && p_wen === 8'h00, "reserved read");
      chk(p_rd === 1'b0, "reserved read strobe");
      end_sim();
   end
endmodule : io_space_decoder_bench
`default_nettype wire
